// ---- core/dcm_map.svh ----
// offsets, field positions, reset values and timing values in ns of the dma block
// assumes a 100 MHz clock for all cycle conversions
`ifndef DCM_MAP_SVH
`define DCM_MAP_SVH
`define DCM_CLK_NS 10
`define DCM_NS2CYC(t) (((t) + `DCM_CLK_NS - 1) / `DCM_CLK_NS)
`define DCM_A_CFG 8'h00
`define DCM_A_STAT 8'h04
`define DCM_A_COUNT 8'h08
`define DCM_A_DATA 8'h0C
`define DCM_A_PIO 8'h10
`define DCM_A_CMD 8'h30
`define DCM_CMD_RESET 8'hFF
`define DCM_CMD_READBACK 32'h000000FF
`define DCM_OP_SLV_IN 8'h00
`define DCM_OP_SLV_OUT 8'h01
`define DCM_OP_MW_IN 8'h06
`define DCM_OP_MW_OUT 8'h07
`define DCM_OP_PIO_RD 8'h0A
`define DCM_F_BO 1:0
`define DCM_F_EOTP 2
`define DCM_F_ACKP 3
`define DCM_F_REQP 4
`define DCM_F_WRP 5
`define DCM_F_RDP 6
`define DCM_F_MST 7
`define DCM_F_ATA 8
`define DCM_F_MW 10:9
`define DCM_F_PIO 13:11
`define DCM_F_WID 14
`define DCM_CFG_W 15
`define DCM_CFG_RESET 15'h0000
`define DCM_BO_SWAP 2'h1
`define DCM_S_BUSY 8
`define DCM_S_DONE 9
`define DCM_BUS_IDLE 16'hFFFF
`define DCM_FIFO_W 16
`define DCM_FIFO_D 16
`define DCM_MW0_ACT_NS 215
`define DCM_MW0_REC_NS 215
`define DCM_MW1_ACT_NS 80
`define DCM_MW1_REC_NS 50
`define DCM_MW2_ACT_NS 70
`define DCM_MW2_REC_NS 30
`define DCM_PIO0_ACT_NS 165
`define DCM_PIO0_REC_NS 435
`define DCM_PIO1_ACT_NS 125
`define DCM_PIO1_REC_NS 260
`define DCM_PIO2_ACT_NS 100
`define DCM_PIO2_REC_NS 140
`define DCM_PIO3_ACT_NS 80
`define DCM_PIO3_REC_NS 100
`define DCM_PIO4_ACT_NS 70
`define DCM_PIO4_REC_NS 50
`define DCM_HOST_STB_NS 100
`define DCM_HOST_REC_NS 50
`endif

// ---- core/dcm_pkg.sv ----
// types shared by both ends of the dma link
// no constants here; numbers live in dcm_map.svh
package dcm_pkg;
  typedef enum logic [2:0] {
    DCM_IDLE = 3'h0,
    DCM_SLV = 3'h1,
    DCM_MST = 3'h2,
    DCM_ACT = 3'h3,
    DCM_REC = 3'h4
  } dcm_state_e;
  typedef enum logic [1:0] {
    DCM_H_IDLE = 2'h0,
    DCM_H_ACT = 2'h1,
    DCM_H_REC = 2'h2
  } dcm_hstate_e;
endpackage : dcm_pkg

// ---- core/dcm_if.sv ----
// link between the dma block and the far party
// bus level is resolved here from both output enables, pulled high if idle
`timescale 1ns/10ps
`default_nettype none
`include "dcm_map.svh"
interface dcm_if;
  logic dev_req;
  logic dev_ack;
  logic dev_rd_stb;
  logic dev_wr_stb;
  logic [15:0] dev_data;
  logic dev_data_oe_n;
  logic far_req;
  logic far_ack;
  logic far_rd_stb;
  logic far_wr_stb;
  logic far_eot;
  logic [15:0] far_data;
  logic far_data_oe_n;
  logic [15:0] bus;
  assign bus = !dev_data_oe_n ? dev_data :
               !far_data_oe_n ? far_data : `DCM_BUS_IDLE;
  modport dev (
    output dev_req, dev_ack, dev_rd_stb, dev_wr_stb, dev_data, dev_data_oe_n,
    input far_req, far_ack, far_rd_stb, far_wr_stb, far_eot, bus
  );
  modport far (
    output far_req, far_ack, far_rd_stb, far_wr_stb, far_eot, far_data,
    output far_data_oe_n,
    input dev_req, dev_ack, dev_rd_stb, dev_wr_stb, dev_data_oe_n, bus
  );
endinterface : dcm_if
`default_nettype wire

// ---- core/dcm_fifo.sv ----
// synchronous fifo with valid/ready on both sides
// single clock; level counts stored words
`timescale 1ns/10ps
`default_nettype none
module dcm_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic [$clog2(D):0] level
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  wire logic push = in_valid & in_ready;
  wire logic pop = out_valid & out_ready;
  assign in_ready = level != (AW+1)'(D);
  assign out_valid = level != '0;
  assign out_data = mem[rp];
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wp <= '0;
      rp <= '0;
      level <= '0;
    end else begin
      if (push) wp <= wp + 1'b1;
      if (pop) rp <= rp + 1'b1;
      level <= level + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  always_ff @(posedge mclk) begin
    if (push) mem[wp] <= in_data;
  end
endmodule : dcm_fifo
`default_nettype wire

// ---- core/dcm_device.sv ----
// dma command and mode control, device end
// avalon-mm slave for software; link partner keeps its own handshake
`timescale 1ns/10ps
`default_nettype none
`include "dcm_map.svh"
// Contract
// - slave honours eot polarity, master ignores
// - software sets master bit per transfer kind
// - per-signal handshake polarities, both modes
// - software sets ata select before 06h/07h
// - multiword strobe timing from mode field
// - pio cycle timing from mode field
// - data bus floats until first command
// - command byte at 30h, reads FFh
// - transfers start only by command write
// - pio transfers always 16 bits
// - 00h: bus into buffer, far write strobe
// - 01h: buffer onto bus, far read strobe
// - 06h bus in, 07h bus out
module dcm_device (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  dcm_if.dev lnk
);
  dcm_pkg::dcm_state_e state;
  logic [`DCM_CFG_W-1:0] cfg;
  logic [15:0] count;
  logic [7:0] cmd;
  logic [7:0] tmr;
  logic armed;
  logic done;
  logic rd_had;
  logic [15:0] pio_data;
  logic wr_q;
  logic rd_q;
  logic ack_q;
  logic f_in_ready;
  logic f_out_valid;
  logic [15:0] f_out_data;
  logic [4:0] f_level;

  function automatic logic [7:0] cyc(input logic pio, input logic rec,
                                     input logic [2:0] m);
    logic [31:0] ns;
    ns = 0;
    if (!pio) begin
      case (m[1:0])
        2'h0: ns = rec ? `DCM_MW0_REC_NS : `DCM_MW0_ACT_NS;
        2'h1: ns = rec ? `DCM_MW1_REC_NS : `DCM_MW1_ACT_NS;
        default: ns = rec ? `DCM_MW2_REC_NS : `DCM_MW2_ACT_NS;
      endcase
    end else begin
      case (m)
        3'h0: ns = rec ? `DCM_PIO0_REC_NS : `DCM_PIO0_ACT_NS;
        3'h1: ns = rec ? `DCM_PIO1_REC_NS : `DCM_PIO1_ACT_NS;
        3'h2: ns = rec ? `DCM_PIO2_REC_NS : `DCM_PIO2_ACT_NS;
        3'h3: ns = rec ? `DCM_PIO3_REC_NS : `DCM_PIO3_ACT_NS;
        default: ns = rec ? `DCM_PIO4_REC_NS : `DCM_PIO4_ACT_NS;
      endcase
    end
    cyc = 8'(`DCM_NS2CYC(ns) - 1);
  endfunction : cyc

  function automatic logic [15:0] fmt(input logic [15:0] w,
                                      input logic [`DCM_CFG_W-1:0] c);
    if (!c[`DCM_F_WID]) fmt = {8'h00, w[7:0]};
    else if (c[`DCM_F_BO] == `DCM_BO_SWAP) fmt = {w[7:0], w[15:8]};
    else fmt = w;
  endfunction : fmt

  // polarity bit 1 means active high
  // inbound polarities
  wire logic far_req_on = ~(lnk.far_req ^ cfg[`DCM_F_REQP]);
  wire logic far_ack_on = ~(lnk.far_ack ^ cfg[`DCM_F_ACKP]);
  wire logic far_wr_on = ~(lnk.far_wr_stb ^ cfg[`DCM_F_WRP]);
  wire logic far_rd_on = ~(lnk.far_rd_stb ^ cfg[`DCM_F_RDP]);
  wire logic eot_on = ~(lnk.far_eot ^ cfg[`DCM_F_EOTP]);
  wire logic pio = cmd == `DCM_OP_PIO_RD;
  wire logic dir_in = cmd == `DCM_OP_SLV_IN || cmd == `DCM_OP_MW_IN;
  wire logic busy = state != dcm_pkg::DCM_IDLE;
  wire logic room = dir_in ? f_in_ready : f_out_valid;

  wire logic rd_fire = avs_read & ~avs_waitrequest;
  wire logic wr_fire = avs_write & ~avs_waitrequest;
  wire logic a_cfg = avs_address == `DCM_A_CFG;
  wire logic a_stat = avs_address == `DCM_A_STAT;
  wire logic a_count = avs_address == `DCM_A_COUNT;
  wire logic a_data = avs_address == `DCM_A_DATA;
  wire logic a_pio = avs_address == `DCM_A_PIO;
  wire logic a_cmd = avs_address == `DCM_A_CMD;
  // full buffer holds a data write in wait
  wire logic stall = avs_write & a_data & ~dir_in & ~f_in_ready;
  wire logic bus_push = wr_fire & a_data & ~dir_in;
  wire logic bus_pop = rd_fire & a_data & dir_in & rd_had;

  wire logic [7:0] op = avs_writedata[7:0];
  // slave codes need master bit 0
  wire logic ok_slv = (op == `DCM_OP_SLV_IN || op == `DCM_OP_SLV_OUT) &&
                      !cfg[`DCM_F_MST];
  wire logic ok_mst = (op == `DCM_OP_MW_IN || op == `DCM_OP_MW_OUT) &&
                      (cfg[`DCM_F_MST] || cfg[`DCM_F_ATA]);
  // only known codes start, when idle
  wire logic go = wr_fire & a_cmd & ~busy &
                  (ok_slv | ok_mst | op == `DCM_OP_PIO_RD);

  // slave word completes on the trailing strobe edge under ack
  // far strobes per direction
  wire logic slv_word = state == dcm_pkg::DCM_SLV && ack_q &&
                        (dir_in ? (wr_q & ~far_wr_on) : (rd_q & ~far_rd_on));
  wire logic act_end = state == dcm_pkg::DCM_ACT && tmr == 8'h00;
  wire logic mst_word = act_end & ~pio;
  wire logic [15:0] word_in = fmt(lnk.bus, cfg);
  wire logic link_push = dir_in & (slv_word | mst_word);
  wire logic link_pop = ~dir_in & ~pio & (slv_word | mst_word);
  wire logic last = count == 16'h0001;
  wire logic slv_end = state == dcm_pkg::DCM_SLV &&
                       (eot_on || count == 16'h0000 || (slv_word && last));
  wire logic rec_end = state == dcm_pkg::DCM_REC && tmr == 8'h00;
  wire logic fin = slv_end || (rec_end && (pio || count == 16'h0000)) ||
                   (state == dcm_pkg::DCM_MST && count == 16'h0000);
  wire logic done_clr = wr_fire & a_stat & avs_writedata[`DCM_S_DONE];

  dcm_fifo #(
    .W(`DCM_FIFO_W),
    .D(`DCM_FIFO_D)
  ) u_fifo (
    .mclk(mclk),
    .nrst(nrst),
    .in_valid(dir_in ? link_push : bus_push),
    .in_ready(f_in_ready),
    .in_data(dir_in ? word_in : avs_writedata[15:0]),
    .out_valid(f_out_valid),
    .out_ready(dir_in ? bus_pop : link_pop),
    .out_data(f_out_data),
    .level(f_level)
  );

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      rd_had <= 1'b0;
    end else begin
      avs_waitrequest <= avs_waitrequest ?
                         ~((avs_read | avs_write) & ~stall) : 1'b1;
      if (avs_read & avs_waitrequest) begin
        rd_had <= f_out_valid;
        // command byte reads back all ones
        avs_readdata <= a_cmd ? `DCM_CMD_READBACK :
                        a_cfg ? 32'(cfg) :
                        a_stat ? {17'h0, f_level, done, busy, cmd} :
                        a_count ? {16'h0000, count} :
                        a_data ? (f_out_valid ? {16'h0000, f_out_data} : '0) :
                        a_pio ? {16'h0000, pio_data} : 32'h00000000;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cfg <= `DCM_CFG_RESET;
      cmd <= `DCM_CMD_RESET;
      armed <= 1'b0;
      done <= 1'b0;
    end else begin
      if (wr_fire & a_cfg) cfg <= avs_writedata[`DCM_CFG_W-1:0];
      if (go) cmd <= op;
      if (go) armed <= 1'b1;
      // finish wins over a clear in the same cycle
      done <= fin | (done & ~done_clr);
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      ack_q <= 1'b0;
      pio_data <= 16'h0000;
    end else begin
      wr_q <= far_wr_on;
      rd_q <= far_rd_on;
      ack_q <= far_ack_on;
      // pio word kept at full 16 bits
      if (act_end & pio) pio_data <= lnk.bus;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state <= dcm_pkg::DCM_IDLE;
      count <= 16'h0000;
      tmr <= 8'h00;
    end else begin
      if (wr_fire & a_count & ~busy) count <= avs_writedata[15:0];
      else if (slv_word | mst_word) count <= count - 16'h0001;
      case (state)
        dcm_pkg::DCM_IDLE: begin
          if (go && ok_slv) state <= dcm_pkg::DCM_SLV;
          else if (go && ok_mst) state <= dcm_pkg::DCM_MST;
          else if (go) begin
            state <= dcm_pkg::DCM_ACT;
            tmr <= cyc(1'b1, 1'b0, cfg[`DCM_F_PIO]);
          end
        end
        dcm_pkg::DCM_SLV: begin
          if (slv_end) state <= dcm_pkg::DCM_IDLE;
        end
        dcm_pkg::DCM_MST: begin
          if (count == 16'h0000) state <= dcm_pkg::DCM_IDLE;
          else if (far_req_on && room) begin
            state <= dcm_pkg::DCM_ACT;
            tmr <= cyc(1'b0, 1'b0, {1'b0, cfg[`DCM_F_MW]});
          end
        end
        dcm_pkg::DCM_ACT: begin
          if (tmr != 8'h00) tmr <= tmr - 8'h01;
          else begin
            state <= dcm_pkg::DCM_REC;
            tmr <= pio ? cyc(1'b1, 1'b1, cfg[`DCM_F_PIO]) :
                   cyc(1'b0, 1'b1, {1'b0, cfg[`DCM_F_MW]});
          end
        end
        dcm_pkg::DCM_REC: begin
          if (tmr != 8'h00) tmr <= tmr - 8'h01;
          else if (pio || count == 16'h0000) state <= dcm_pkg::DCM_IDLE;
          else state <= dcm_pkg::DCM_MST;
        end
        default: state <= dcm_pkg::DCM_IDLE;
      endcase
    end
  end

  // link outputs; reset constants equal inactive for the reset polarities
  wire logic strobe_on = state == dcm_pkg::DCM_ACT;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      lnk.dev_req <= 1'b1;
      lnk.dev_ack <= 1'b1;
      lnk.dev_rd_stb <= 1'b1;
      lnk.dev_wr_stb <= 1'b1;
      lnk.dev_data <= 16'h0000;
      lnk.dev_data_oe_n <= 1'b1;
    end else begin
      lnk.dev_req <= ~((state == dcm_pkg::DCM_SLV && count != 16'h0000 &&
                        room) ^ cfg[`DCM_F_REQP]);
      lnk.dev_ack <= ~((strobe_on & ~pio) ^ cfg[`DCM_F_ACKP]);
      lnk.dev_rd_stb <= ~((strobe_on & (dir_in | pio)) ^ cfg[`DCM_F_RDP]);
      lnk.dev_wr_stb <= ~((strobe_on & ~dir_in & ~pio) ^ cfg[`DCM_F_WRP]);
      // word held through recovery so the far end sees it at strobe end
      if (state != dcm_pkg::DCM_REC) lnk.dev_data <= fmt(f_out_data, cfg);
      lnk.dev_data_oe_n <= ~(armed & busy & ~dir_in & ~pio);
    end
  end
endmodule : dcm_device
`default_nettype wire

// ---- core/dcm_host.sv ----
// far party of the dma link: external controller or ata-style device
// user side is a source stream, a sink pulse and a fixed pio word
`timescale 1ns/10ps
`default_nettype none
`include "dcm_map.svh"
module dcm_host (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ctl_role,
  input wire logic to_device,
  input wire logic acknowledge_polarity,
  input wire logic req_pol,
  input wire logic wr_pol,
  input wire logic rd_pol,
  input wire logic end_of_transfer_polarity,
  input wire logic src_valid,
  output logic src_ready,
  input wire logic [15:0] src_data,
  output logic snk_valid,
  output logic [15:0] snk_data,
  input wire logic eot_req,
  input wire logic [15:0] pio_word,
  dcm_if.far lnk
);
  localparam logic [7:0] STB = 8'(`DCM_NS2CYC(`DCM_HOST_STB_NS) - 1);
  localparam logic [7:0] REC = 8'(`DCM_NS2CYC(`DCM_HOST_REC_NS) - 1);
  dcm_pkg::dcm_hstate_e state;
  logic [7:0] tmr;
  logic rd_q;
  logic wr_q;
  logic ack_q;
  wire logic dreq_on = ~(lnk.dev_req ^ req_pol);
  wire logic dack_on = ~(lnk.dev_ack ^ acknowledge_polarity);
  wire logic drd_on = ~(lnk.dev_rd_stb ^ rd_pol);
  wire logic dwr_on = ~(lnk.dev_wr_stb ^ wr_pol);
  wire logic start = ctl_role && state == dcm_pkg::DCM_H_IDLE && dreq_on &&
                     (!to_device || src_valid);
  wire logic act_end = state == dcm_pkg::DCM_H_ACT && tmr == 8'h00;
  wire logic act = state == dcm_pkg::DCM_H_ACT;
  // device-role words end on the device's trailing strobe
  // ack drops with the strobe, so the word is judged on the held ack
  wire logic d_rd_end = !ctl_role && rd_q && !drd_on && ack_q;
  wire logic d_wr_end = !ctl_role && wr_q && !dwr_on && ack_q;
  wire logic drive = ctl_role ? (act & to_device) : drd_on;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state <= dcm_pkg::DCM_H_IDLE;
      tmr <= 8'h00;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      ack_q <= 1'b0;
    end else begin
      rd_q <= drd_on;
      wr_q <= dwr_on;
      ack_q <= dack_on;
      case (state)
        dcm_pkg::DCM_H_IDLE: begin
          if (start) begin
            state <= dcm_pkg::DCM_H_ACT;
            tmr <= STB;
          end
        end
        dcm_pkg::DCM_H_ACT: begin
          if (tmr != 8'h00) tmr <= tmr - 8'h01;
          else begin
            state <= dcm_pkg::DCM_H_REC;
            tmr <= REC;
          end
        end
        dcm_pkg::DCM_H_REC: begin
          if (tmr != 8'h00) tmr <= tmr - 8'h01;
          else state <= dcm_pkg::DCM_H_IDLE;
        end
        default: state <= dcm_pkg::DCM_H_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      src_ready <= 1'b0;
      snk_valid <= 1'b0;
      snk_data <= 16'h0000;
      lnk.far_req <= 1'b1;
      lnk.far_ack <= 1'b1;
      lnk.far_rd_stb <= 1'b1;
      lnk.far_wr_stb <= 1'b1;
      lnk.far_eot <= 1'b1;
      lnk.far_data <= 16'h0000;
      lnk.far_data_oe_n <= 1'b1;
    end else begin
      src_ready <= (act_end & to_device) | (d_rd_end & to_device);
      snk_valid <= (act_end & ~to_device) | d_wr_end;
      if ((act_end & ~to_device) | d_wr_end) snk_data <= lnk.bus;
      lnk.far_req <= ~((!ctl_role && (!to_device || src_valid)) ^ req_pol);
      lnk.far_ack <= ~((start | (act & ~act_end)) ^ acknowledge_polarity);
      // write strobe carries words into the device
      lnk.far_wr_stb <= ~(((start | (act & ~act_end)) & to_device) ^ wr_pol);
      // read strobe takes words out of the device
      lnk.far_rd_stb <= ~(((start | (act & ~act_end)) & ~to_device) ^ rd_pol);
      lnk.far_eot <= ~(eot_req ^ end_of_transfer_polarity);
      lnk.far_data <= (ctl_role || dack_on) ? src_data : pio_word;
      lnk.far_data_oe_n <= ~drive;
    end
  end
endmodule : dcm_host
`default_nettype wire

// ---- bench/dcm_monitor.sv ----
// link checker: timing and ownership relations on the dma link wires
// fed with the link signals; one clock domain, mclk with nrst
`timescale 1ns/10ps
`default_nettype none
module dcm_monitor (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic dev_ack,
  input wire logic dev_rd_stb,
  input wire logic dev_wr_stb,
  input wire logic dev_data_oe_n,
  input wire logic far_ack,
  input wire logic far_rd_stb,
  input wire logic far_wr_stb,
  input wire logic far_eot,
  input wire logic far_data_oe_n
);
  logic [1:0] since_rst;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      since_rst <= 2'h0;
    end else if (since_rst != 2'h3) begin
      since_rst <= since_rst + 2'h1;
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  property p_float;
    since_rst != 2'h3 |-> dev_data_oe_n;
  endproperty
  a_float: assert property (p_float)
    else $error("device drove the bus right after reset");
  property p_one_driver;
    !(!dev_data_oe_n && !far_data_oe_n);
  endproperty
  a_one_driver: assert property (p_one_driver)
    else $error("both ends drive the bus");
  property p_host_wr_hold;
    $changed(far_wr_stb) |=> $stable(far_wr_stb) [*4];
  endproperty
  a_host_wr_hold: assert property (p_host_wr_hold)
    else $error("host write strobe too short");
  property p_host_rd_hold;
    $changed(far_rd_stb) |=> $stable(far_rd_stb) [*4];
  endproperty
  a_host_rd_hold: assert property (p_host_rd_hold)
    else $error("host read strobe too short");
  property p_dev_rd_hold;
    $changed(dev_rd_stb) |=> $stable(dev_rd_stb) [*2];
  endproperty
  a_dev_rd_hold: assert property (p_dev_rd_hold)
    else $error("device read strobe phase too short");
  property p_dev_wr_hold;
    $changed(dev_wr_stb) |=> $stable(dev_wr_stb) [*2];
  endproperty
  a_dev_wr_hold: assert property (p_dev_wr_hold)
    else $error("device write strobe phase too short");
  property p_eot_pulse;
    $fell(far_eot) |=> $rose(far_eot);
  endproperty
  a_eot_pulse: assert property (p_eot_pulse)
    else $error("end of transfer pulse not one cycle");
  property p_host_ack_stb;
    $changed(far_ack) |-> $changed(far_wr_stb) || $changed(far_rd_stb);
  endproperty
  a_host_ack_stb: assert property (p_host_ack_stb)
    else $error("host acknowledge moved without a strobe");
  property p_dev_ack_stb;
    $changed(dev_ack) |-> $changed(dev_rd_stb) || $changed(dev_wr_stb);
  endproperty
  a_dev_ack_stb: assert property (p_dev_ack_stb)
    else $error("device acknowledge moved without a strobe");
  c_slave: cover property ($changed(far_wr_stb));
  c_eot: cover property ($fell(far_eot));
  c_drive: cover property ($fell(dev_data_oe_n));
endmodule : dcm_monitor
`default_nettype wire

// ---- bench/dcm_tb.sv ----
// bench: device and host ends joined by the link interface
// drives the avalon port and the host user side; judges both
`timescale 1ns/10ps
`default_nettype none
`include "dcm_map.svh"
module dcm_tb;
  logic mclk, nrst, avs_read, avs_write, avs_waitrequest;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic ctl_role, to_device, hpol, src_valid, src_ready;
  logic snk_valid, eot_req;
  logic [15:0] src_data, snk_data, pio_word;
  logic [15:0] src_q[$];
  logic [15:0] snk_q[$];
  int errors, num_checks, cycles, stb_cnt;
  dcm_if lnk();
  dcm_device i_dcm_device (.mclk(mclk), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .lnk(lnk));
  dcm_host i_dcm_host (.mclk(mclk), .nrst(nrst), .ctl_role(ctl_role),
    .to_device(to_device), .acknowledge_polarity(hpol), .req_pol(hpol), .wr_pol(hpol),
    .rd_pol(hpol), .end_of_transfer_polarity(1'b0), .src_valid(src_valid),
    .src_ready(src_ready), .src_data(src_data), .snk_valid(snk_valid),
    .snk_data(snk_data), .eot_req(eot_req), .pio_word(pio_word), .lnk(lnk));
  dcm_monitor i_dcm_monitor (.mclk(mclk), .nrst(nrst),
    .dev_ack(lnk.dev_ack), .dev_rd_stb(lnk.dev_rd_stb),
    .dev_wr_stb(lnk.dev_wr_stb), .dev_data_oe_n(lnk.dev_data_oe_n),
    .far_ack(lnk.far_ack), .far_rd_stb(lnk.far_rd_stb),
    .far_wr_stb(lnk.far_wr_stb), .far_eot(lnk.far_eot),
    .far_data_oe_n(lnk.far_data_oe_n));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // source feeder holds each word until the host takes it
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      summarize();
    end
    if (snk_valid === 1'b1) snk_q.push_back(snk_data);
    if (lnk.dev_rd_stb === 1'b1) stb_cnt++;
    if (src_valid && src_ready) void'(src_q.pop_front());
    src_valid <= src_q.size() != 0;
    src_data <= (src_q.size() != 0) ? src_q[0] : 16'h0000;
  end
  task automatic summarize();
    if (errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk
  task automatic wait_done();
    do bus(1'b0, `DCM_A_STAT, 32'h0); while (rd[`DCM_S_DONE] !== 1'b1);
    bus(1'b1, `DCM_A_STAT, 32'h00000200);
  endtask : wait_done
  // polarity swap happens with the host passive, so no stray transfer
  task automatic setup(input logic [31:0] cfg, input logic pol,
                       input logic role, input logic dir);
    ctl_role <= 1'b0;
    bus(1'b1, `DCM_A_CFG, cfg);
    hpol <= pol;
    repeat (4) @(posedge mclk);
    snk_q.delete();
    ctl_role <= role;
    to_device <= dir;
  endtask : setup
  task automatic go(input logic [31:0] cnt, input logic [7:0] cmd);
    bus(1'b1, `DCM_A_COUNT, cnt);
    bus(1'b1, `DCM_A_CMD, {24'h0, cmd});
  endtask : go
  task automatic t_idle();
    rdchk(`DCM_A_CFG, 32'h0);
    rdchk(`DCM_A_CMD, `DCM_CMD_READBACK);
    rdchk(8'h40, 32'h0);
    for (int c = 0; c < 7; c++) begin
      bus(1'b1, `DCM_A_CFG, (c < 2) ? 32'h80 : 32'h0);
      go(32'h3, 8'(c));
      bus(1'b0, `DCM_A_STAT, 32'h0);
      chk({23'h0, rd[8:0]}, 32'h0FF);
    end
    chk({16'h0, lnk.bus}, 32'h0000FFFF);
  endtask : t_idle
  task automatic t_slave_in();
    setup(32'h4079, 1'b1, 1'b1, 1'b1);
    src_q = '{16'h1234, 16'hABCD};
    go(32'h2, `DCM_OP_SLV_IN);
    wait_done();
    rdchk(`DCM_A_DATA, 32'h3412);
    rdchk(`DCM_A_DATA, 32'hCDAB);
  endtask : t_slave_in
  task automatic t_eot();
    setup(32'h4000, 1'b0, 1'b1, 1'b1);
    go(32'hA, `DCM_OP_SLV_IN);
    eot_req <= 1'b1;
    @(posedge mclk);
    eot_req <= 1'b0;
    wait_done();
    rdchk(`DCM_A_COUNT, 32'hA);
  endtask : t_eot
  task automatic t_fill_drain();
    setup(32'h4078, 1'b1, 1'b1, 1'b0);
    // data port accepts but drops writes while an inbound command is current
    go(32'h0, `DCM_OP_SLV_OUT);
    wait_done();
    for (int i = 0; i < 16; i++) bus(1'b1, `DCM_A_DATA, 32'h0100 + i);
    bus(1'b0, `DCM_A_STAT, 32'h0);
    chk({27'h0, rd[14:10]}, 32'h10);
    go(32'h10, `DCM_OP_SLV_OUT);
    bus(1'b0, `DCM_A_STAT, 32'h0);
    chk({31'h0, lnk.dev_data_oe_n}, 32'h0);
    wait_done();
    chk(32'(snk_q.size()), 32'h10);
    for (int i = 0; i < snk_q.size(); i++) begin
      chk({16'h0, snk_q[i]}, 32'h0100 + i);
    end
  endtask : t_fill_drain
  task automatic t_master();
    int act[3] = '{22, 8, 7};
    for (int m = 0; m < 3; m++) begin
      setup(32'h4178 | (32'(m) << 9), 1'b1, 1'b0, 1'b1);
      src_q.push_back(16'h5A00 + 16'(m));
      stb_cnt = 0;
      go(32'h1, `DCM_OP_MW_IN);
      eot_req <= 1'b1;
      @(posedge mclk);
      eot_req <= 1'b0;
      wait_done();
      chk(32'(stb_cnt), 32'(act[m]));
      rdchk(`DCM_A_DATA, 32'h5A00 + 32'(m));
    end
    setup(32'h4578, 1'b1, 1'b0, 1'b0);
    go(32'h0, `DCM_OP_MW_OUT);
    wait_done();
    bus(1'b1, `DCM_A_DATA, 32'hC001);
    bus(1'b1, `DCM_A_DATA, 32'hC002);
    go(32'h2, `DCM_OP_MW_OUT);
    wait_done();
    chk({snk_q[0], snk_q[1]}, 32'hC001C002);
  endtask : t_master
  task automatic t_pio();
    int cyc[5] = '{17, 13, 10, 8, 7};
    for (int m = 0; m < 5; m++) begin
      setup(32'h0178 | (32'(m) << 11), 1'b1, 1'b0, 1'b0);
      pio_word <= 16'hA55A ^ 16'(m);
      stb_cnt = 0;
      bus(1'b1, `DCM_A_CMD, {24'h0, `DCM_OP_PIO_RD});
      wait_done();
      chk(32'(stb_cnt), 32'(cyc[m]));
      rdchk(`DCM_A_PIO, {16'h0, 16'hA55A ^ 16'(m)});
    end
  endtask : t_pio
  initial begin
    nrst = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    {ctl_role, to_device, hpol, src_valid, eot_req} = 5'h00;
    src_data = 16'h0000;
    pio_word = 16'h0000;
    errors = 0;
    num_checks = 0;
    cycles = 0;
    stb_cnt = 0;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    t_idle();
    t_slave_in();
    t_eot();
    t_fill_drain();
    t_master();
    t_pio();
    summarize();
  end
endmodule : dcm_tb
`default_nettype wire
